//--- verif/afr_storage_sva.sv
`timescale 1ns/1ps
module afr_storage_sva
    import afr_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic data_valid_in,
    input wire logic data_in,
    input wire logic data_ready_out,
    input wire afr_chain_ctl_s chain_ctl_in,
    input wire logic tap_out,
    input wire logic chain_out,
    input wire afr_flop_ctl_s flop_ctl_in,
    input wire logic flop_q_out
);
    // Own fill count, since a shift on an empty buffer is idle
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic pop;
    assign pop = chain_ctl_in.shift_en && cnt != 3'h0;
    always_comb
        next_cnt = cnt + 3'(data_valid_in && data_ready_out) - 3'(pop);
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
        if (!arst_n_in)
            cnt <= 3'h0;
        else
            cnt <= next_cnt;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    AST_NO_POP: assert property (!pop |=> $stable(chain_out))
        else $error("chain moved");
    AST_TAP_LAST: assert property (chain_ctl_in.tap_sel == AFR_TAP_LAST |=> tap_out == chain_out)
        else $error("tap 31 off");
    AST_SHIFT_ON: assert property ((pop && chain_ctl_in.tap_sel == 5'h1E) ##1 pop
        |=> chain_out == $past(tap_out)) else $error("no shift");
    AST_TAP_HOLD: assert property (!pop && $stable(chain_ctl_in.tap_sel) |=> $stable(tap_out))
        else $error("tap moved");
    AST_CLEAR: assert property (flop_ctl_in.force_level |=> !flop_q_out)
        else $error("clear lost");
    AST_LOAD: assert property (!flop_ctl_in.force_level && flop_ctl_in.enable
        |=> flop_q_out == $past(flop_ctl_in.data)) else $error("load lost");
    AST_HOLD: assert property (!flop_ctl_in.force_level && !flop_ctl_in.enable
        |=> $stable(flop_q_out)) else $error("flop moved");
    AST_INIT: assert property ($rose(arst_n_in)
        |-> !flop_q_out && !chain_out && !tap_out && data_ready_out) else $error("bad reset");
endmodule
bind afr_storage afr_storage_sva i_sva (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .data_valid_in(data_valid_in), .data_in(data_in), .data_ready_out(data_ready_out),
    .chain_ctl_in(chain_ctl_in), .tap_out(tap_out), .chain_out(chain_out),
    .flop_ctl_in(flop_ctl_in), .flop_q_out(flop_q_out));

//--- verif/afr_storage_tb_top.sv
`timescale 1ns/1ps
module afr_storage_tb_top
    import afr_pkg::*;
;
    logic clk_sys_in = 1'h0;
    logic arst_n_in = 1'h0;
    logic data_valid_in = 1'h0;
    logic data_in = 1'h0;
    afr_chain_ctl_s chain_ctl_in = '0;
    afr_flop_ctl_s flop_ctl_in = '0;
    logic data_ready_out, tap_out, chain_out, flop_q_out, tap_q, qf, texp;
    logic [31:0] m;
    logic fq[$];
    int n_mismatch = 0;
    int total_checks = 0;
    always #50 clk_sys_in = ~clk_sys_in;
    afr_storage i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .data_valid_in(data_valid_in),
        .data_in(data_in), .data_ready_out(data_ready_out), .chain_ctl_in(chain_ctl_in), .tap_out(tap_out),
        .chain_out(chain_out), .flop_ctl_in(flop_ctl_in), .flop_q_out(flop_q_out));
    afr_user_reg i_user (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .tap_in(tap_out), .tap_q_out(tap_q));
    task automatic check(input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %b", $time, seen);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic step(input logic v, input logic d, input logic sh, input logic [4:0] sel, input afr_flop_ctl_s fc);
        logic full;
        logic empty;
        @(negedge clk_sys_in);
        data_valid_in = v;
        data_in = d;
        chain_ctl_in = '{sh, sel};
        flop_ctl_in = fc;
        full = fq.size() == 4;
        empty = fq.size() == 0;
        @(posedge clk_sys_in);
        if (sh && !empty)
            m = {m[30:0], fq.pop_front()};
        if (v && !full)
            fq.push_back(d);
        if (fc.force_level)
            qf = 1'h0;
        else if (fc.enable)
            qf = fc.data;
        #1;
        check(tap_out, m[sel]);
        check(chain_out, m[31]);
        check(data_ready_out, fq.size() != 4);
        check(tap_q, texp);
        check(flop_q_out, qf);
        texp = m[sel];
    endtask
    task automatic do_reset();
        @(negedge clk_sys_in);
        arst_n_in = 1'h0;
        data_valid_in = 1'h0;
        chain_ctl_in = '0;
        flop_ctl_in = '0;
        #1;
        check(flop_q_out, 1'h0);
        check(chain_out, 1'h0);
        check(tap_out, 1'h0);
        check(data_ready_out, 1'h1);
        repeat (12) @(negedge clk_sys_in);
        arst_n_in = 1'h1;
        m = '0;
        fq.delete();
        qf = 1'h0;
        texp = 1'h0;
    endtask
    // Full buffer refuses, then drains past empty
    task automatic s_fill();
        for (int i = 0; i < 6; i++)
            step(1'h1, i[0], 1'h0, 5'h00, '0);
        for (int i = 0; i < 7; i++)
            step(1'h0, 1'h0, 1'h1, 5'(i), '0);
    endtask
    task automatic s_taps();
        logic [4:0] sels[5] = '{5'h00, 5'h06, 5'h07, 5'h1E, 5'h1F};
        foreach (sels[j])
            for (int i = 0; i < 40; i++)
                step(1'h1, i % 3 == 0, 1'h1, sels[j], '0);
    endtask
    task automatic s_flop();
        logic [2:0] seq[10] = '{3'h6, 3'h0, 3'h5, 3'h4, 3'h6, 3'h7, 3'h6, 3'h2, 3'h1, 3'h3};
        foreach (seq[k])
            step(1'h0, 1'h0, 1'h0, 5'h1F, seq[k]);
    endtask
    task automatic s_mid_reset();
        for (int i = 0; i < 40; i++)
            step(1'h1, 1'h1, i < 36, 5'h1F, 3'h6);
        do_reset();
    endtask
    initial
    begin
        do_reset();
        s_fill();
        s_taps();
        s_flop();
        s_mid_reset();
        s_fill();
        stop_test();
    end
    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule

//--- verif/afr_user_reg.sv
`timescale 1ns/1ps
module afr_user_reg
(
    // Clock, reset, tap
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic tap_in,
    // Registered tap
    output logic tap_q_out
);
    logic next_q;
    always_comb
        next_q = tap_in;
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
        if (!arst_n_in)
            tap_q_out <= 1'h0;
        else
            tap_q_out <= next_q;
endmodule

//--- verilog/afr_pkg.sv
package afr_pkg;

    // Shift chain geometry
    localparam int AFR_STAGES = 32;
    localparam int AFR_TAP_W = 5;
    localparam logic [AFR_TAP_W-1:0] AFR_TAP_LAST = 5'h1F;

    // Data FIFO in front of the chain
    localparam int AFR_FIFO_DEPTH = 4;
    localparam int AFR_FIFO_WIDTH = 1;

    // Values after reset
    localparam logic [AFR_STAGES-1:0] AFR_CHAIN_RESET = 32'h0000_0000;
    localparam logic AFR_BIT_ZERO = 1'h0;
    localparam logic AFR_BIT_ONE = 1'h1;

    // Clock edge choice: 0 rising, 1 falling
    localparam logic AFR_EDGE_RISING = 1'h0;

    // Flip-flop variants, one-hot
    typedef enum logic [3:0] {
        AFR_FLOP_SYNC_ZERO = 4'h1,
        AFR_FLOP_SYNC_ONE = 4'h2,
        AFR_FLOP_ASYNC_ZERO = 4'h4,
        AFR_FLOP_ASYNC_ONE = 4'h8
    } afr_flop_variant_e;

    // Controls of the single flip-flop
    typedef struct packed {
        logic data;
        logic enable;
        logic force_level;
    } afr_flop_ctl_s;

    // Shift chain controls
    typedef struct packed {
        logic shift_en;
        logic [AFR_TAP_W-1:0] tap_sel;
    } afr_chain_ctl_s;

    // Power-up value of a flop variant
    function automatic logic afr_init_value(input afr_flop_variant_e v);
        case (v)
            AFR_FLOP_SYNC_ONE,
            AFR_FLOP_ASYNC_ONE: afr_init_value = AFR_BIT_ONE;
            default: afr_init_value = AFR_BIT_ZERO;
        endcase
    endfunction

endpackage

//--- verilog/afr_storage.sv
`timescale 1ns/1ps

// What this block does
// - Shift clock edge is selectable, rising by default.
// - With shift enable low, edges neither shift nor load.
// - Enabled edge with a buffered bit loads it into stage 0 and moves all bits on.
// - Tap select 0..31 picks the stage driving the tap output.
// - Chain output always shows stage 31 and follows every shift.
// - Length at the tap is tap select plus one stages.
// - Flip-flop captures data on the chosen edge and holds it.
// - Enable low blocks data loads but not clear or preset.
// - Sync clear variant forces output low on the edge, overriding all.
// - Sync preset variant forces output high on the edge, overriding all.
// - Async clear variant forces output low at once, overriding all.
// - Async preset variant forces output high at once, overriding all.
// - Clear variants power up at zero, preset variants at one.
module afr_storage
    import afr_pkg::*;
#(
    parameter logic CLK_FALLING = AFR_EDGE_RISING,
    parameter afr_flop_variant_e FLOP_VARIANT = AFR_FLOP_SYNC_ZERO,
    parameter int STAGES = AFR_STAGES,
    parameter int FIFO_DEPTH = AFR_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // Serial data stream into the chain
    input wire logic data_valid_in,
    input wire logic data_in,
    output logic data_ready_out,
    // Chain controls
    input wire afr_chain_ctl_s chain_ctl_in,
    // Chain outputs
    output logic tap_out,
    output logic chain_out,
    // Flip-flop
    input wire afr_flop_ctl_s flop_ctl_in,
    output logic flop_q_out
);
    logic clk_edge;
    logic fifo_valid;
    logic fifo_data;
    logic shift_now;

    assign clk_edge = CLK_FALLING ? ~clk_sys_in : clk_sys_in;

    // Buffer decouples the stream from shift enable; a shift with nothing buffered is idle
    afr_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_edge),
        .arst_n_in(arst_n_in),
        .in_valid_in(data_valid_in),
        .in_data_in(data_in),
        .in_ready_out(data_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(chain_ctl_in.shift_en)
    );

    // no shift without enable and data
    assign shift_now = chain_ctl_in.shift_en && fifo_valid;

    afr_addressable_shift_chain #(
        .STAGES(STAGES)
    ) u_chain (
        .clk_in(clk_edge),
        .arst_n_in(arst_n_in),
        .shift_en_in(shift_now),
        .data_in(fifo_data),
        .tap_sel_in(chain_ctl_in.tap_sel),
        .tap_out(tap_out),
        .chain_out(chain_out)
    );

    // One clock, inverted only when CLK_FALLING is set, serves FIFO, chain and flop, so a single edge choice covers all storage
    afr_flop #(
        .VARIANT(FLOP_VARIANT)
    ) u_flop (
        .clk_in(clk_edge),
        .arst_n_in(arst_n_in),
        .ctl_in(flop_ctl_in),
        .q_out(flop_q_out)
    );
endmodule

module afr_fifo
    import afr_pkg::*;
#(
    parameter int WIDTH = AFR_FIFO_WIDTH,
    parameter int DEPTH = AFR_FIFO_DEPTH
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // Drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic [PW-1:0] next_wr_ptr;
    logic [PW-1:0] next_rd_ptr;
    logic [PW:0] next_count;
    logic push;
    logic pop;
    logic next_ready;
    logic next_valid;
    logic [WIDTH-1:0] next_mem [DEPTH];

    // Wraps at DEPTH, so depths that are not a power of two work as well
    function automatic logic [PW-1:0] afr_ptr_inc(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1))
            afr_ptr_inc = '0;
        else
            afr_ptr_inc = p + PW'(1);
    endfunction

    // Flags are registered from the next count, so no gate sits behind the outputs
    assign out_data_out = mem[rd_ptr];

    always_comb
    begin
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        next_wr_ptr = push ? afr_ptr_inc(wr_ptr) : wr_ptr;
        next_rd_ptr = pop ? afr_ptr_inc(rd_ptr) : rd_ptr;
        next_count = count;
        if (push && !pop)
            next_count = count + (PW+1)'(1);
        else if (pop && !push)
            next_count = count - (PW+1)'(1);
        next_ready = (next_count != (PW+1)'(DEPTH));
        next_valid = (next_count != '0);
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_out <= AFR_BIT_ONE;
            out_valid_out <= AFR_BIT_ZERO;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready_out <= next_ready;
            out_valid_out <= next_valid;
        end
    end

    // Storage is not reset; the slot at rd_ptr is only consumed while out_valid_out is high
    always_comb
    begin
        next_mem = mem;
        if (push)
            next_mem[wr_ptr] = in_data_in;
    end

    always_ff @(posedge clk_in)
    begin
        mem <= next_mem;
    end
endmodule

module afr_flop
    import afr_pkg::*;
#(
    parameter afr_flop_variant_e VARIANT = AFR_FLOP_SYNC_ZERO
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Controls
    input wire afr_flop_ctl_s ctl_in,
    // Registered output
    output logic q_out
);
    localparam logic INIT_VAL = afr_init_value(VARIANT);
    localparam logic IS_ASYNC = (VARIANT == AFR_FLOP_ASYNC_ZERO) || (VARIANT == AFR_FLOP_ASYNC_ONE);

    logic async_force;
    logic next_q;

    // Only async variants let the force line into the sensitivity list
    assign async_force = IS_ASYNC ? ctl_in.force_level : 1'h0;

    always_comb
    begin
        next_q = q_out;
        if (VARIANT == AFR_FLOP_SYNC_ZERO && ctl_in.force_level)
            next_q = AFR_BIT_ZERO;
        else if (VARIANT == AFR_FLOP_SYNC_ONE && ctl_in.force_level)
            next_q = AFR_BIT_ONE;
        else if (ctl_in.enable)
            next_q = ctl_in.data;
    end

    always_ff @(posedge clk_in or negedge arst_n_in or posedge async_force)
    begin
        if (!arst_n_in)
            q_out <= INIT_VAL;
        else if (async_force)
            q_out <= INIT_VAL;
        else
            q_out <= next_q;
    end
endmodule

module afr_addressable_shift_chain
    import afr_pkg::*;
#(
    parameter int STAGES = AFR_STAGES
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Serial input
    input wire logic shift_en_in,
    input wire logic data_in,
    // Tap select
    input wire logic [AFR_TAP_W-1:0] tap_sel_in,
    // Registered outputs
    output logic tap_out,
    output logic chain_out
);
    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;
    logic next_tap;
    logic next_chain_out;

    // One stage mux serves the tap and the cascade output
    // Limitation: a select beyond STAGES-1 reads past the chain, so keep STAGES at 32
    function automatic logic afr_stage_pick(input logic [STAGES-1:0] stages_v, input logic [AFR_TAP_W-1:0] idx);
        afr_stage_pick = stages_v[idx];
    endfunction

    always_comb
    begin
        next_chain = chain;
        // load stage 0, move the rest
        if (shift_en_in)
            next_chain = {chain[STAGES-2:0], data_in};
        // tap depth is select plus one
        next_tap = afr_stage_pick(next_chain, tap_sel_in);
        next_chain_out = afr_stage_pick(next_chain, AFR_TAP_W'(STAGES - 1));
    end

    // Tap is registered from the next chain so it stays aligned with the shift;
    // a change of tap select alone shows one edge later
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            chain <= AFR_CHAIN_RESET[STAGES-1:0];
            tap_out <= AFR_BIT_ZERO;
            chain_out <= AFR_BIT_ZERO;
        end
        else
        begin
            chain <= next_chain;
            tap_out <= next_tap;
            chain_out <= next_chain_out;
        end
    end
endmodule
